// ---- verilog/sdbc_pkg.sv ----
package sdbc_pkg;

	// ********************************************************************
	// Geometry and pin fields
	// ********************************************************************
	localparam int NUM_BANKS    = 4;
	localparam int BANK_W       = 2;
	localparam int ADDR_W       = 12;
	localparam int CNT_W        = 10;
	localparam int AUTO_PRECHARGE_ADDR_BIT = 10;

	// Mode register fields held on the address pins during a mode load
	localparam int MODE_BURST_LSB = 0;
	localparam int MODE_BURST_W   = 3;
	localparam int MODE_LAT_LSB   = 4;
	localparam int MODE_LAT_W     = 3;
	localparam logic [MODE_BURST_W-1:0] BURST_RESET     = 3'h0;
	localparam logic [MODE_BURST_W-1:0] BURST_FULL_PAGE = 3'h7;
	localparam logic [MODE_LAT_W-1:0]   LATENCY_RESET   = 3'h3;
	localparam int FULL_PAGE_LEN = 256;
	localparam int MAX_LATENCY   = 7;

	// ********************************************************************
	// Timing, printed in ns, converted to whole 40 ns cycles
	// ********************************************************************
	localparam int CLK_PERIOD_PS                = 40000;
	localparam int PRECHARGE_PERIOD_NS          = 20;
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS  = 20;
	localparam int ROW_CYCLE_TIME_NS            = 70;
	localparam int MODE_SET_DELAY_NS            = 80;
	localparam int SELF_REFRESH_EXIT_DELAY_NS   = 80;

	// Least times round up, never below one cycle
	function automatic int sdbc_cycles(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// ********************************************************************
	// Commands and states
	// ********************************************************************
	typedef enum logic [3:0] {
		CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
		CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
	} sdbc_cmd_type;

	typedef enum logic [2:0] {
		BK_IDLE        = 3'h0,
		BK_ACTIVATING  = 3'h1,
		BK_ACTIVE      = 3'h3,
		BK_READING     = 3'h2,
		BK_WRITING     = 3'h6,
		BK_READ_AP     = 3'h7,
		BK_WRITE_AP    = 3'h5,
		BK_PRECHARGING = 3'h4
	} sdbc_bank_type;

	typedef enum logic [2:0] {
		GL_NORMAL   = 3'h0,
		GL_REFRESH  = 3'h1,
		GL_MODE     = 3'h3,
		GL_PRE_ALL  = 3'h2,
		GL_SELF_REF = 3'h6,
		GL_SR_EXIT  = 3'h7
	} sdbc_glob_type;

endpackage

// ---- verilog/sdbc_bank.sv ----
`timescale 1ns/1ps
module sdbc_bank
	import sdbc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire sdbc_cmd_type     cmd,
	input  wire logic             go,
	input  wire logic             hit,
	input  wire logic             auto_pre,
	input  wire logic             other_burst,
	input  wire logic             stop,
	input  wire logic             pre_all,
	input  wire logic             endless,
	input  wire logic [CNT_W-1:0] burst_len,
	input  wire logic [CNT_W-1:0] t_rp,
	input  wire logic [CNT_W-1:0] t_rcd,
	output sdbc_bank_type         state
);
	logic [CNT_W-1:0] cnt;
	logic             col_go;

	assign col_go = go && hit && (cmd == CMD_READ || cmd == CMD_WRITE);

	// ****************************************************************
	// Bank state and its timing counter
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= BK_IDLE;
			cnt   <= '0;
		end else begin
			unique case (state)
			BK_IDLE: begin
				// Precharge here changes nothing
				if (go && hit && cmd == CMD_ACTIVE) begin
					state <= BK_ACTIVATING;
					cnt   <= t_rcd - 1'b1;
				end
			end
			BK_ACTIVATING, BK_PRECHARGING: begin
				if (cnt == '0)
					state <= (state == BK_ACTIVATING) ? BK_ACTIVE : BK_IDLE;
				else
					cnt <= cnt - 1'b1;
			end
			BK_ACTIVE, BK_READING, BK_WRITING: begin
				if (go && ((hit && cmd == CMD_PRECHARGE) || pre_all)) begin
					state <= BK_PRECHARGING;
					cnt   <= t_rp - 1'b1;
				end else if (col_go) begin
					if (auto_pre) begin
						state <= (cmd == CMD_READ) ? BK_READ_AP : BK_WRITE_AP;
						cnt   <= burst_len + t_rp - 1'b1;
					end else begin
						state <= (cmd == CMD_READ) ? BK_READING : BK_WRITING;
						cnt   <= burst_len - 1'b1;
					end
				end else if (state != BK_ACTIVE) begin
					// Burst cut short by a stop or a burst elsewhere
					if (stop || other_burst || (cnt == '0 && !endless))
						state <= BK_ACTIVE;
					else if (cnt != '0)
						cnt <= cnt - 1'b1;
				end
			end
			BK_READ_AP, BK_WRITE_AP: begin
				if (other_burst && cnt > t_rp - 1'b1)
					cnt <= t_rp - 1'b1;
				else if (cnt == '0)
					state <= BK_IDLE;
				else
					cnt <= cnt - 1'b1;
			end
			endcase
		end
	end

endmodule

// ---- verilog/sdbc_top.sv ----
`timescale 1ns/1ps
module sdbc_top
	import sdbc_pkg::*;
#(
	parameter int T_RP_CYC  = sdbc_cycles(PRECHARGE_PERIOD_NS),
	parameter int T_RCD_CYC = sdbc_cycles(ACTIVATE_TO_COLUMN_DELAY_NS),
	parameter int T_RC_CYC  = sdbc_cycles(ROW_CYCLE_TIME_NS),
	parameter int T_MRD_CYC = sdbc_cycles(MODE_SET_DELAY_NS),
	parameter int T_XSR_CYC = sdbc_cycles(SELF_REFRESH_EXIT_DELAY_NS)
)(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    cke,
	input  wire logic                    cs_n,
	input  wire logic                    ras_n,
	input  wire logic                    cas_n,
	input  wire logic                    we_n,
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic [BANK_W-1:0]       bank_select_bits,
	output logic [NUM_BANKS*3-1:0]       bank_state,
	output logic                         all_banks_idle,
	output logic                         device_busy,
	output logic                         self_refresh,
	output logic                         cmd_illegal,
	output logic                         data_owner_valid,
	output logic                         data_owner_write,
	output logic [BANK_W-1:0]            data_owner_bank
);
	localparam int PIN_W = 5 + BANK_W + ADDR_W;
	localparam logic [CNT_W-1:0] RP_CNT  = CNT_W'(T_RP_CYC);
	localparam logic [CNT_W-1:0] RCD_CNT = CNT_W'(T_RCD_CYC);
	localparam logic [CNT_W-1:0] RC_CNT  = CNT_W'(T_RC_CYC);
	localparam logic [CNT_W-1:0] MRD_CNT = CNT_W'(T_MRD_CYC);
	localparam logic [CNT_W-1:0] XSR_CNT = CNT_W'(T_XSR_CYC);
	localparam logic [CNT_W-1:0] PAGE_CNT = CNT_W'(FULL_PAGE_LEN);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic             cke_prev;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= {PIN_W{1'b1}};
			pin_sync <= {PIN_W{1'b1}};
		end else begin
			pin_meta <= {cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr};
			pin_sync <= pin_meta;
		end
	end

	logic              s_cke;
	logic              s_cs_n;
	logic              s_ras_n;
	logic              s_cas_n;
	logic              s_we_n;
	logic [BANK_W-1:0] s_bank;
	logic [ADDR_W-1:0] s_addr;
	assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr} = pin_sync;

	// Enable level from the previous edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cke_prev <= 1'b1;
		else
			cke_prev <= s_cke;
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************
	sdbc_cmd_type cmd;
	logic         auto_pre;

	always_comb begin
		if (s_cs_n)
			cmd = CMD_INHIBIT;
		else
			unique case ({s_ras_n, s_cas_n, s_we_n})
			3'h7: cmd = CMD_NOP;
			3'h3: cmd = CMD_ACTIVE;
			3'h5: cmd = CMD_READ;
			3'h4: cmd = CMD_WRITE;
			3'h6: cmd = CMD_BURST_STOP;
			3'h2: cmd = CMD_PRECHARGE;
			3'h1: cmd = CMD_REFRESH;
			3'h0: cmd = CMD_MODE_LOAD;
			endcase
	end

	assign auto_pre = s_addr[AUTO_PRECHARGE_ADDR_BIT];

	// ****************************************************************
	// Bank machines
	// ****************************************************************
	sdbc_bank_type    st [NUM_BANKS];
	logic             go;
	logic             pre_all_go;
	logic             endless;
	logic [CNT_W-1:0] burst_len;
	logic             stop_live;
	logic [BANK_W-1:0] stop_bank;
	logic [MODE_BURST_W-1:0] mode_burst;
	logic [MODE_LAT_W-1:0]   mode_lat;

	assign pre_all_go = go && cmd == CMD_PRECHARGE && auto_pre;
	assign endless    = (mode_burst == BURST_FULL_PAGE);

	// Burst length decoded from the mode field
	always_comb begin
		unique case (mode_burst)
		3'h0:    burst_len = CNT_W'(1);
		3'h1:    burst_len = CNT_W'(2);
		3'h2:    burst_len = CNT_W'(4);
		3'h3:    burst_len = CNT_W'(8);
		default: burst_len = PAGE_CNT;
		endcase
	end

	logic [NUM_BANKS-1:0] idle_vec;
	logic [NUM_BANKS-1:0] preok_vec;

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic hit;
			assign hit = (s_bank == BANK_W'(b));
			// One independent machine per bank
			sdbc_bank u_bank (
				.clk         (clk),
				.resetn      (resetn),
				.cmd         (cmd),
				.go          (go),
				.hit         (hit && !(cmd == CMD_PRECHARGE && auto_pre)),
				.auto_pre    (auto_pre),
				.other_burst (go && !hit && (cmd == CMD_READ || cmd == CMD_WRITE)),
				.stop        (go && cmd == CMD_BURST_STOP && stop_bank == BANK_W'(b)),
				.pre_all     (pre_all_go),
				.endless     (endless),
				.burst_len   (burst_len),
				.t_rp        (RP_CNT),
				.t_rcd       (RCD_CNT),
				.state       (st[b])
			);
			assign bank_state[b*3 +: 3] = st[b];
			assign idle_vec[b]  = (st[b] == BK_IDLE);
			assign preok_vec[b] = st[b] inside {BK_IDLE, BK_ACTIVE, BK_READING, BK_WRITING};
		end
	endgenerate

	assign all_banks_idle = &idle_vec;

	// ****************************************************************
	// Legality check
	// ****************************************************************
	sdbc_glob_type   gstate;
	logic [CNT_W-1:0] gcnt;
	sdbc_bank_type    tgt;
	logic             exec;
	logic             legal;
	logic             sr_entry;

	assign tgt = st[s_bank];
	// Executable commands only with enable high on both edges, except a refresh with enable falling, which enters self refresh
	assign exec     = (cmd != CMD_INHIBIT) && (cmd != CMD_NOP);
	assign sr_entry = cke_prev && !s_cke && cmd == CMD_REFRESH && !s_cs_n;

	always_comb begin
		unique case (cmd)
		CMD_ACTIVE:     legal = (tgt == BK_IDLE);
		CMD_READ,
		CMD_WRITE:      legal = tgt inside {BK_ACTIVE, BK_READING, BK_WRITING};
		CMD_PRECHARGE:  legal = auto_pre ? (&preok_vec) : preok_vec[s_bank];
		CMD_BURST_STOP: legal = stop_live && st[stop_bank] inside {BK_READING, BK_WRITING};
		CMD_REFRESH,
		CMD_MODE_LOAD:  legal = all_banks_idle;
		default:        legal = 1'b1;
		endcase
	end

	// Transient global states allow no executable command
	assign go = exec && legal && cke_prev && s_cke && gstate == GL_NORMAL;

	// Flag anything unlisted; behaviour after it is not promised
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cmd_illegal <= 1'b0;
		else
			cmd_illegal <= cke_prev && s_cke && exec && (gstate != GL_NORMAL || !legal);
	end

	// ****************************************************************
	// Global busy states
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gstate <= GL_NORMAL;
			gcnt   <= '0;
		end else begin
			unique case (gstate)
			GL_NORMAL: begin
				if (sr_entry && all_banks_idle) begin
					gstate <= GL_SELF_REF;
				end else if (go && cmd == CMD_REFRESH) begin
					gstate <= GL_REFRESH;
					gcnt   <= RC_CNT - 1'b1;
				end else if (go && cmd == CMD_MODE_LOAD) begin
					gstate <= GL_MODE;
					gcnt   <= MRD_CNT - 1'b1;
				end else if (pre_all_go) begin
					gstate <= GL_PRE_ALL;
					gcnt   <= RP_CNT - 1'b1;
				end
			end
			GL_REFRESH, GL_MODE, GL_PRE_ALL, GL_SR_EXIT: begin
				if (gcnt == '0)
					gstate <= GL_NORMAL;
				else
					gcnt <= gcnt - 1'b1;
			end
			GL_SELF_REF: begin
				// Exit delay counts from the enable rising
				if (s_cke) begin
					gstate <= GL_SR_EXIT;
					gcnt   <= XSR_CNT - 1'b1;
				end
			end
			endcase
		end
	end

	assign device_busy  = (gstate != GL_NORMAL);
	assign self_refresh = (gstate == GL_SELF_REF);

	// ****************************************************************
	// Mode register and most recent burst
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_burst <= BURST_RESET;
			mode_lat   <= LATENCY_RESET;
		end else if (go && cmd == CMD_MODE_LOAD) begin
			mode_burst <= s_addr[MODE_BURST_LSB +: MODE_BURST_W];
			mode_lat   <= s_addr[MODE_LAT_LSB +: MODE_LAT_W];
		end
	end

	// Auto-precharge bursts cannot be stopped, so they clear the track
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stop_live <= 1'b0;
			stop_bank <= '0;
		end else if (go && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
			stop_live <= !auto_pre;
			stop_bank <= s_bank;
		end else if (go && cmd == CMD_BURST_STOP) begin
			stop_live <= 1'b0;
		end
	end

	// ****************************************************************
	// Data bus ownership
	// ****************************************************************
	logic [MAX_LATENCY-1:0] pend_v;
	logic [BANK_W-1:0]      pend_b [MAX_LATENCY];
	logic                   rd_go;
	logic                   wr_go;

	assign rd_go = go && cmd == CMD_READ;
	assign wr_go = go && cmd == CMD_WRITE;

	// Read ownership travels down a latency line; a write flushes it
	genvar p;
	generate
		for (p = 0; p < MAX_LATENCY; p++) begin : g_pend
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					pend_v[p] <= 1'b0;
					pend_b[p] <= '0;
				end else if (wr_go) begin
					pend_v[p] <= 1'b0;
				end else if (rd_go && mode_lat == MODE_LAT_W'(p + 1)) begin
					pend_v[p] <= 1'b1;
					pend_b[p] <= s_bank;
				end else if (p == MAX_LATENCY - 1) begin
					pend_v[p] <= 1'b0;
				end else begin
					// Wrapped index keeps the last stage's unused branch in range
					pend_v[p] <= pend_v[(p + 1) % MAX_LATENCY];
					pend_b[p] <= pend_b[(p + 1) % MAX_LATENCY];
				end
			end
		end
	endgenerate

	// Owner held while its bank is still bursting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_owner_valid <= 1'b0;
			data_owner_write <= 1'b0;
			data_owner_bank  <= '0;
		end else if (wr_go) begin
			data_owner_valid <= 1'b1;
			data_owner_write <= 1'b1;
			data_owner_bank  <= s_bank;
		end else if (pend_v[0]) begin
			data_owner_valid <= 1'b1;
			data_owner_write <= 1'b0;
			data_owner_bank  <= pend_b[0];
		end else if (st[data_owner_bank] inside {BK_IDLE, BK_ACTIVE, BK_PRECHARGING, BK_ACTIVATING}) begin
			data_owner_valid <= 1'b0;
		end
	end

endmodule

// ---- test/sdbc_top_chk.sv ----
`timescale 1ns/1ps
module sdbc_top_chk
	import sdbc_pkg::*;
#(
	parameter int T_RP_CYC  = 1,
	parameter int T_RCD_CYC = 1,
	parameter int T_RC_CYC  = 2,
	parameter int T_MRD_CYC = 2,
	parameter int T_XSR_CYC = 2
)(
	input wire logic                   clk,
	input wire logic                   resetn,
	input wire logic [NUM_BANKS*3-1:0] bank_state,
	input wire logic                   all_banks_idle,
	input wire logic                   device_busy,
	input wire logic                   self_refresh,
	input wire logic                   data_owner_valid,
	input wire logic                   data_owner_write,
	input wire logic [BANK_W-1:0]      data_owner_bank
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ******
	// Run lengths, read in the cycle a value changes
	// ******
	logic [2:0]       prev_st [NUM_BANKS];
	logic [CNT_W-1:0] run     [NUM_BANKS];
	logic             prev_busy;
	logic             sr_span;
	logic [CNT_W-1:0] busy_run;

	// Per-bank run length
	always_ff @(posedge clk or negedge resetn) begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (!resetn) begin
				prev_st[b] <= 3'h0;
				run[b]     <= '0;
			end else begin
				prev_st[b] <= bank_state[3*b +: 3];
				run[b]     <= (bank_state[3*b +: 3] != prev_st[b]) ? CNT_W'(1) : run[b] + 1'b1;
			end
		end
	end

	// Busy run length; self refresh spans are open-ended, so left out
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_busy <= 1'b0;
			sr_span   <= 1'b0;
			busy_run  <= '0;
		end else begin
			prev_busy <= device_busy;
			sr_span   <= device_busy & (sr_span | self_refresh);
			busy_run  <= (device_busy != prev_busy) ? CNT_W'(1) : busy_run + 1'b1;
		end
	end

	// Per-bank state sequencing
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		logic [2:0] st;
		logic [2:0] pv;
		assign st = bank_state[3*b +: 3];
		assign pv = prev_st[b];
		property p_act_span;
			pv == BK_ACTIVATING && st != BK_ACTIVATING |-> run[b] == T_RCD_CYC && st == BK_ACTIVE;
		endproperty
		a_act_span: assert property (p_act_span) else $error("activating span wrong");
		property p_pre_span;
			pv == BK_PRECHARGING && st != BK_PRECHARGING |-> run[b] == T_RP_CYC && st == BK_IDLE;
		endproperty
		a_pre_span: assert property (p_pre_span) else $error("precharging span wrong");
		property p_ap_end;
			pv inside {BK_READ_AP, BK_WRITE_AP} && st != pv |-> st == BK_IDLE && run[b] > T_RP_CYC;
		endproperty
		a_ap_end: assert property (p_ap_end) else $error("auto precharge end wrong");
		property p_act_entry;
			st == BK_ACTIVATING && pv != BK_ACTIVATING |-> pv == BK_IDLE;
		endproperty
		a_act_entry: assert property (p_act_entry) else $error("activate from non-idle");
		property p_active_entry;
			st == BK_ACTIVE && pv != BK_ACTIVE |-> pv inside {BK_ACTIVATING, BK_READING, BK_WRITING};
		endproperty
		a_active_entry: assert property (p_active_entry) else $error("row active entered wrongly");
		property p_busy_freeze;
			device_busy |=> st == prev_st[b] || st inside {BK_IDLE, BK_PRECHARGING};
		endproperty
		a_busy_freeze: assert property (p_busy_freeze) else $error("bank moved while busy");
		property p_write_owner;
			st inside {BK_WRITING, BK_WRITE_AP} && !(pv inside {BK_WRITING, BK_WRITE_AP})
				|-> ##[0:1] data_owner_valid && data_owner_write && data_owner_bank == BANK_W'(b);
		endproperty
		a_write_owner: assert property (p_write_owner) else $error("write owner missing");
	end

	// Device-wide flags
	property p_idle_flag;
		all_banks_idle == (bank_state == '0);
	endproperty
	a_idle_flag: assert property (p_idle_flag) else $error("idle flag disagrees");
	property p_busy_end;
		prev_busy && !device_busy && !sr_span
			|-> busy_run inside {T_RC_CYC, T_MRD_CYC, T_RP_CYC, T_XSR_CYC} && all_banks_idle;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy span wrong");
	property p_self_busy;
		self_refresh |-> device_busy;
	endproperty
	a_self_busy: assert property (p_self_busy) else $error("self refresh not busy");
endmodule

bind sdbc_top sdbc_top_chk #(.T_RP_CYC(T_RP_CYC), .T_RCD_CYC(T_RCD_CYC), .T_RC_CYC(T_RC_CYC),
	.T_MRD_CYC(T_MRD_CYC), .T_XSR_CYC(T_XSR_CYC)) sdbc_top_chk_i (
	.clk(clk), .resetn(resetn), .bank_state(bank_state), .all_banks_idle(all_banks_idle),
	.device_busy(device_busy), .self_refresh(self_refresh), .data_owner_valid(data_owner_valid),
	.data_owner_write(data_owner_write), .data_owner_bank(data_owner_bank)
);

// ---- test/sdbc_ctrl_model.sv ----
`timescale 1ns/1ps
module sdbc_ctrl_model
	import sdbc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic [NUM_BANKS*3-1:0] bank_state,
	input  wire logic                   all_banks_idle,
	input  wire logic                   device_busy,
	output logic                        cke,
	output logic                        cs_n,
	output logic                        ras_n,
	output logic                        cas_n,
	output logic                        we_n,
	output logic [ADDR_W-1:0]           addr,
	output logic [BANK_W-1:0]           bank_select_bits
);
	// Deselected at power-up, clock enable high
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = '0;
		bank_select_bits = '0;
	end

	// One command for one cycle; a polite caller first waits for the
	// device and the target bank, a rude one is for refusal tests
	task automatic issue(input logic [3:0] code, input logic [BANK_W-1:0] bk,
		input logic [ADDR_W-1:0] ad, input logic rude);
		logic [2:0] st;
		for (int i = 0; i < 40 && !rude; i++) begin
			@(negedge clk);
			st = bank_state[3*bk +: 3];
			if (!device_busy && !(st inside {BK_ACTIVATING, BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP})
				&& (all_banks_idle || code[2:1] != 2'b00)) break;
		end
		@(negedge clk);
		{cs_n, ras_n, cas_n, we_n} = code;
		addr = ad;
		bank_select_bits = bk;
		// Back to no-operation; don't-care lines flip so nothing stale lingers
		@(negedge clk);
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		addr = ~ad;
		bank_select_bits = ~bk;
	endtask

	// Clock enable moves on a falling edge
	task automatic set_cke(input logic v);
		@(negedge clk);
		cke = v;
	endtask
endmodule

// ---- test/tb_sdbc_bank_command_legality.sv ----
`timescale 1ns/1ps
module tb_sdbc_bank_command_legality
	import sdbc_pkg::*;
;
	localparam int PRECHARGE_PERIOD  = 3;
	localparam int ACTIVATE_TO_COLUMN_DELAY = 2;
	localparam int ROW_CYCLE_TIME  = 5;
	localparam int MODE_SET_DELAY = 4;
	localparam logic [3:0] C_ACT = 4'h3;
	localparam logic [3:0] C_RD  = 4'h5;
	localparam logic [3:0] C_WR  = 4'h4;
	localparam logic [3:0] C_BST = 4'h6;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_REF = 4'h1;
	localparam logic [3:0] C_MRS = 4'h0;

	logic                   clk;
	logic                   resetn;
	logic                   cke;
	logic                   cs_n;
	logic                   ras_n;
	logic                   cas_n;
	logic                   we_n;
	logic [ADDR_W-1:0]      addr;
	logic [BANK_W-1:0]      bank_select_bits;
	logic [NUM_BANKS*3-1:0] bank_state;
	logic                   all_banks_idle;
	logic                   device_busy;
	logic                   cmd_illegal;
	logic                   illegal_seen;
	int                     mismatches;
	int                     samples_checked;

	sdbc_top #(.T_RP_CYC(PRECHARGE_PERIOD), .T_RCD_CYC(ACTIVATE_TO_COLUMN_DELAY), .T_RC_CYC(ROW_CYCLE_TIME), .T_MRD_CYC(MODE_SET_DELAY), .T_XSR_CYC(3)) sdbc_top_i (
		.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.addr(addr), .bank_select_bits(bank_select_bits), .bank_state(bank_state),
		.all_banks_idle(all_banks_idle), .device_busy(device_busy), .self_refresh(),
		.cmd_illegal(cmd_illegal), .data_owner_valid(), .data_owner_write(), .data_owner_bank()
	);

	sdbc_ctrl_model sdbc_ctrl_model_i (
		.clk(clk), .bank_state(bank_state), .all_banks_idle(all_banks_idle), .device_busy(device_busy),
		.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
		.bank_select_bits(bank_select_bits)
	);

	// Free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Sticky refusal flag, cleared by the test that reads it
	always @(posedge clk) if (cmd_illegal === 1'b1) illegal_seen <= 1'b1;

	// ******
	// Shared helpers
	// ******
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Index 4 stands for the busy flag
	function automatic logic [2:0] get(input int w);
		return (w < 4) ? bank_state[3*w +: 3] : {2'b00, device_busy};
	endfunction

	task automatic go(input logic [3:0] code, input logic [1:0] bk, input logic [11:0] ad);
		sdbc_ctrl_model_i.issue(code, bk, ad, 1'b0);
	endtask

	// Waits for a state, times how long it stands, then checks span and successor
	task automatic span(input int w, input logic [2:0] s, input int n, input logic [2:0] nxt);
		int k;
		int c;
		k = 0;
		c = 0;
		while (get(w) !== s && k < 8) begin
			@(negedge clk);
			k++;
		end
		while (get(w) === s && c < 300) begin
			@(negedge clk);
			c++;
		end
		if (n >= 0) check(12'(c), 12'(n));
		check({9'h0, get(w)}, {9'h0, nxt});
	endtask

	// ******
	// Scenarios
	// ******
	task automatic t_row_cycle();
		go(C_ACT, 2'h1, 12'h000);
		span(1, BK_ACTIVATING, ACTIVATE_TO_COLUMN_DELAY, BK_ACTIVE);
		go(C_RD, 2'h1, 12'h000);
		span(1, BK_READING, 1, BK_ACTIVE);
		go(C_WR, 2'h1, 12'h000);
		span(1, BK_WRITING, 1, BK_ACTIVE);
		go(C_WR, 2'h1, 12'h400);
		span(1, BK_WRITE_AP, 1 + PRECHARGE_PERIOD, BK_IDLE);
		go(C_ACT, 2'h2, 12'h000);
		span(2, BK_ACTIVATING, ACTIVATE_TO_COLUMN_DELAY, BK_ACTIVE);
		go(C_RD, 2'h2, 12'h400);
		span(2, BK_READ_AP, 1 + PRECHARGE_PERIOD, BK_IDLE);
		$display("Row cycle test done");
	endtask

	task automatic t_precharge();
		go(C_ACT, 2'h0, 12'h000);
		span(0, BK_ACTIVATING, ACTIVATE_TO_COLUMN_DELAY, BK_ACTIVE);
		go(C_PRE, 2'h0, 12'h000);
		span(0, BK_PRECHARGING, PRECHARGE_PERIOD, BK_IDLE);
		illegal_seen = 1'b0;
		go(C_PRE, 2'h3, 12'h000);
		repeat (6) @(negedge clk);
		check({bank_state[11:1], illegal_seen}, 12'h000);
		$display("Precharge test done");
	endtask

	task automatic t_global();
		go(C_REF, 2'h0, 12'h000);
		span(4, 3'h1, ROW_CYCLE_TIME, 3'h0);
		go(C_MRS, 2'h0, 12'h037);
		span(4, 3'h1, MODE_SET_DELAY, 3'h0);
		go(C_ACT, 2'h0, 12'h000);
		go(C_ACT, 2'h3, 12'h000);
		span(3, BK_ACTIVATING, ACTIVATE_TO_COLUMN_DELAY, BK_ACTIVE);
		// Full-page read never ends alone; a stop or a burst to another bank returns the bank
		go(C_RD, 2'h0, 12'h000);
		repeat (20) @(negedge clk);
		check({9'h0, get(0)}, {9'h0, BK_READING});
		go(C_BST, 2'h0, 12'h000);
		span(0, BK_READING, -1, BK_ACTIVE);
		go(C_PRE, 2'h2, 12'h400);
		span(4, 3'h1, PRECHARGE_PERIOD, 3'h0);
		check(bank_state, 12'h000);
		$display("Device-wide test done");
	endtask

	task automatic t_refused();
		illegal_seen = 1'b0;
		sdbc_ctrl_model_i.issue(C_RD, 2'h2, 12'h000, 1'b1);
		repeat (6) @(negedge clk);
		check({8'h0, illegal_seen, bank_state[8:6]}, 12'h008);
		illegal_seen = 1'b0;
		go(C_REF, 2'h0, 12'h000);
		sdbc_ctrl_model_i.issue(C_ACT, 2'h1, 12'h000, 1'b1);
		repeat (ROW_CYCLE_TIME + 4) @(negedge clk);
		check({8'h0, illegal_seen, bank_state[5:3]}, 12'h008);
		sdbc_ctrl_model_i.set_cke(1'b0);
		sdbc_ctrl_model_i.issue(C_ACT, 2'h1, 12'h000, 1'b1);
		sdbc_ctrl_model_i.set_cke(1'b1);
		repeat (6) @(negedge clk);
		check(bank_state, 12'h000);
		go(C_ACT, 2'h1, 12'h000);
		span(1, BK_ACTIVATING, ACTIVATE_TO_COLUMN_DELAY, BK_ACTIVE);
		go(C_PRE, 2'h1, 12'h000);
		span(1, BK_PRECHARGING, PRECHARGE_PERIOD, BK_IDLE);
		$display("Refusal test done");
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#120000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	// Main sequence
	initial begin
		mismatches = 0;
		samples_checked = 0;
		illegal_seen = 1'b0;
		resetn = 1'b0;
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		check({bank_state[11:1], all_banks_idle}, 12'h001);
		t_row_cycle();
		t_precharge();
		t_global();
		t_refused();
		tally_and_finish();
	end
endmodule
